// ---- ata_ident_pkg.sv ----
package ata_ident_pkg;
  // task-file register indices; byte address is four times the index
  localparam logic [5:0] REG_DATA = 6'h00;
  localparam logic [5:0] REG_ERR_FEAT = 6'h01;
  localparam logic [5:0] REG_SEC_CNT = 6'h02;
  localparam logic [5:0] REG_SEC_NUM = 6'h03;
  localparam logic [5:0] REG_CYL_LO = 6'h04;
  localparam logic [5:0] REG_CYL_HI = 6'h05;
  localparam logic [5:0] REG_HEAD = 6'h06;
  localparam logic [5:0] REG_STAT_CMD = 6'h07;
  localparam int ADR_LSB = 2;

  // opcodes
  localparam logic [7:0] CMD_FORMAT_TRACK = 8'h50;
  localparam logic [7:0] CMD_IDENTIFY = 8'hec;

  // status, error and head-register bits
  localparam int ST_BSY = 7;
  localparam int ST_DRDY = 6;
  localparam int ST_DSC = 4;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  localparam int ER_ABRT = 2;
  localparam int HEAD_LBA = 6;

  // one sector of 16-bit words
  localparam logic [7:0] LAST_WORD = 8'hff;

  // geometry defaults
  localparam logic [15:0] DEF_CYLS = 16'h03d4;
  localparam logic [15:0] DEF_HEADS = 16'h0010;
  localparam logic [15:0] DEF_SPT = 16'h003f;

  // fixed identify words
  localparam logic [15:0] ID_W0_GENCFG = 16'h044a;
  localparam logic [15:0] ID_W5 = 16'h0200;
  localparam logic [15:0] ID_W20_BUFTYPE = 16'h0002;
  localparam logic [15:0] ID_W47_MULTMAX = 16'h8001;
  localparam logic [15:0] ID_W49_CAPS = 16'h0b00;
  localparam logic [15:0] ID_W51_PIOTIM = 16'h0200;
  localparam logic [15:0] ID_W53_VALID = 16'h0007;
  localparam logic [7:0] ID_W59_VALID_HI = 8'h01;
  localparam logic [7:0] ID_W59_MULT_DEF = 8'h00;
  localparam logic [15:0] ID_W63_MWDMA = 16'h0007;
  localparam logic [15:0] ID_W64_ADVPIO = 16'h0003;
  localparam logic [15:0] ID_W65_68_CYC = 16'h0078;
  localparam logic [15:0] ID_W80_MAJOR = 16'h007e;
  localparam logic [15:0] ID_W81_MINOR = 16'h0019;
  localparam logic [15:0] ID_W82_FEAT = 16'h706b;
  localparam logic [15:0] ID_W83_FEAT = 16'h400c;
  localparam logic [15:0] ID_W84_FEAT = 16'h4000;
  localparam logic [15:0] ID_W88_UDMA = 16'h001f;
  localparam logic [15:0] ID_W163 = 16'h0002;

  // default strings, first character in the high byte of a word
  localparam logic [159:0] DEF_SERIAL = {20{8'h20}};
  localparam logic [63:0] DEF_FW_REV = "REV00001"; // arbitrary value
  localparam logic [319:0] DEF_MODEL = {"480MB", {35{8'h20}}};
endpackage

// ---- ident_rom.sv ----
module ident_rom
  import ata_ident_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [7:0] word_addr,
  input wire logic [7:0] mult_count,
  output logic [15:0] word_q_ff
);
  logic [15:0] nxt_word_q;
  logic [31:0] total;
  logic [7:0] n;

  assign total = 32'(DEF_CYLS) * 32'(DEF_HEADS) * 32'(DEF_SPT);

  // word lookup; every reserved or vendor word falls to zero
  always_comb begin
    n = word_addr;
    nxt_word_q = 16'h0000; // RULE5
    if (n >= 8'd10 && n <= 8'd19) begin
      nxt_word_q = DEF_SERIAL[159 - 16 * (32'(n) - 10) -: 16]; // RULE9
    end else if (n >= 8'd23 && n <= 8'd26) begin
      nxt_word_q = DEF_FW_REV[63 - 16 * (32'(n) - 23) -: 16]; // RULE12
    end else if (n >= 8'd27 && n <= 8'd46) begin
      nxt_word_q = DEF_MODEL[319 - 16 * (32'(n) - 27) -: 16]; // RULE12
    end else if (n >= 8'd65 && n <= 8'd68) begin
      nxt_word_q = ID_W65_68_CYC; // RULE14
    end else begin
      case (n)
        8'd0: nxt_word_q = ID_W0_GENCFG; // RULE6
        8'd1: nxt_word_q = DEF_CYLS; // RULE16
        8'd3: nxt_word_q = DEF_HEADS; // RULE16
        8'd5: nxt_word_q = ID_W5;
        8'd6: nxt_word_q = DEF_SPT; // RULE16
        8'd7: nxt_word_q = total[31:16]; // RULE7
        8'd8: nxt_word_q = total[15:0]; // RULE7
        8'd20: nxt_word_q = ID_W20_BUFTYPE; // RULE10
        8'd47: nxt_word_q = ID_W47_MULTMAX; // RULE11
        8'd49: nxt_word_q = ID_W49_CAPS; // RULE13
        8'd51: nxt_word_q = ID_W51_PIOTIM; // RULE13
        8'd53: nxt_word_q = ID_W53_VALID; // RULE13
        8'd54: nxt_word_q = DEF_CYLS;
        8'd55: nxt_word_q = DEF_HEADS;
        8'd56: nxt_word_q = DEF_SPT;
        8'd57: nxt_word_q = total[15:0]; // RULE8
        8'd58: nxt_word_q = total[31:16]; // RULE8
        8'd59: nxt_word_q = {ID_W59_VALID_HI, mult_count}; // RULE17
        8'd60: nxt_word_q = total[15:0];
        8'd61: nxt_word_q = total[31:16];
        8'd63: nxt_word_q = ID_W63_MWDMA;
        8'd64: nxt_word_q = ID_W64_ADVPIO; // RULE14
        8'd80: nxt_word_q = ID_W80_MAJOR; // RULE15
        8'd81: nxt_word_q = ID_W81_MINOR; // RULE15
        8'd82: nxt_word_q = ID_W82_FEAT; // RULE15
        8'd83: nxt_word_q = ID_W83_FEAT; // RULE15
        8'd84: nxt_word_q = ID_W84_FEAT; // RULE15
        8'd88: nxt_word_q = ID_W88_UDMA;
        8'd163: nxt_word_q = ID_W163;
        default: nxt_word_q = 16'h0000;
      endcase
    end
  end

  // registered read data, one cycle behind the address
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      word_q_ff <= 16'h0000;
    end else begin
      word_q_ff <= nxt_word_q;
    end
  end
endmodule

// ---- ata_identify_format_responder.sv ----
// Behaviour
// (RULE1) format-track accepted, media never formatted
// (RULE2) take one written sector, then discard it
// (RULE3) lba from cylinder, sector-number and head fields
// (RULE4) identify data sent like one-sector read
// (RULE5) reserved identify bits and words read zero
// (RULE6) word 0 reports 044ah
// (RULE7) words 7-8 total sectors, high word first
// (RULE8) words 57-58 capacity, low word first
// (RULE9) words 10-19 serial number, default spaces
// (RULE10) word 20 reports 0002h
// (RULE11) word 47 reports 8001h
// (RULE12) firmware words 23-26, model words 27-46
// (RULE13) words 49, 51, 53 fixed values
// (RULE14) word 64 0003h, words 65-68 0078h
// (RULE15) version and feature words 80-84 fixed
// (RULE16) words 1, 3, 6 default geometry
// (RULE17) word 59 high byte 01h, low default 00h
// (RULE18) 256 words ascending from word 0
module ata_identify_format_responder
  import ata_ident_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o_ff,
  output logic wb_ack_o_ff,
  output logic [27:0] fmt_lba_ff,
  output logic fmt_lba_mode_ff,
  output logic fmt_done_ff
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_ID_PREP, ST_ID_XFER, ST_FMT_XFER, ST_FMT_END
  } phase_t;

  phase_t phase_ff, nxt_phase;
  logic [7:0] ptr_ff, nxt_ptr;
  logic [7:0] seccnt_ff, nxt_seccnt;
  logic [7:0] secnum_ff, nxt_secnum;
  logic [7:0] cyllo_ff, nxt_cyllo;
  logic [7:0] cylhi_ff, nxt_cylhi;
  logic [7:0] head_ff, nxt_head;
  logic [7:0] err_ff, nxt_err;
  logic err_flag_ff, nxt_err_flag;
  logic [27:0] nxt_fmt_lba;
  logic nxt_fmt_lba_mode;
  logic nxt_fmt_done;
  logic [31:0] nxt_dat_o;
  logic nxt_ack;
  logic [15:0] rom_q;
  logic take;
  logic wr_lo;
  logic [5:0] idx;
  logic [7:0] status;

  // a request is taken once; the ack cycle itself never retakes it
  assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o_ff;
  assign wr_lo = take & wb_we_i & wb_sel_i[0];
  assign idx = wb_adr_i[7:ADR_LSB];

  // buffer address follows the word pointer, so the next word is ready early
  ident_rom u_rom (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .word_addr(ptr_ff),
    .mult_count(ID_W59_MULT_DEF), // RULE17
    .word_q_ff(rom_q)
  );

  // status byte assembled from the command phase
  always_comb begin
    status = 8'h00;
    status[ST_BSY] = (phase_ff == ST_ID_PREP) || (phase_ff == ST_FMT_END);
    status[ST_DRDY] = 1'b1;
    status[ST_DSC] = 1'b1;
    status[ST_DRQ] = (phase_ff == ST_ID_XFER) || (phase_ff == ST_FMT_XFER); // RULE4
    status[ST_ERR] = err_flag_ff;
  end

  // bus answer: ack one cycle after the request, unmapped reads give zero
  always_comb begin
    nxt_ack = take;
    nxt_dat_o = 32'h0000_0000;
    if (take && !wb_we_i) begin
      case (idx)
        REG_DATA: nxt_dat_o = (phase_ff == ST_ID_XFER) ? {16'h0000, rom_q} : 32'h0000_0000;
        REG_ERR_FEAT: nxt_dat_o = {24'h000000, err_ff};
        REG_SEC_CNT: nxt_dat_o = {24'h000000, seccnt_ff};
        REG_SEC_NUM: nxt_dat_o = {24'h000000, secnum_ff};
        REG_CYL_LO: nxt_dat_o = {24'h000000, cyllo_ff};
        REG_CYL_HI: nxt_dat_o = {24'h000000, cylhi_ff};
        REG_HEAD: nxt_dat_o = {24'h000000, head_ff};
        REG_STAT_CMD: nxt_dat_o = {24'h000000, status};
        default: nxt_dat_o = 32'h0000_0000;
      endcase
    end
  end

  // task-file registers; the feature byte is write-only and unused here, so it is not kept
  always_comb begin
    nxt_seccnt = seccnt_ff;
    nxt_secnum = secnum_ff;
    nxt_cyllo = cyllo_ff;
    nxt_cylhi = cylhi_ff;
    nxt_head = head_ff;
    // writes are ignored while a command owns the registers
    if (wr_lo && phase_ff == ST_IDLE) begin
      case (idx)
        REG_SEC_CNT: nxt_seccnt = wb_dat_i[7:0];
        REG_SEC_NUM: nxt_secnum = wb_dat_i[7:0];
        REG_CYL_LO: nxt_cyllo = wb_dat_i[7:0];
        REG_CYL_HI: nxt_cylhi = wb_dat_i[7:0];
        REG_HEAD: nxt_head = wb_dat_i[7:0];
        default: nxt_head = head_ff;
      endcase
    end
  end

  // task-file storage
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      seccnt_ff <= 8'h00;
      secnum_ff <= 8'h00;
      cyllo_ff <= 8'h00;
      cylhi_ff <= 8'h00;
      head_ff <= 8'h00;
    end else begin
      seccnt_ff <= nxt_seccnt;
      secnum_ff <= nxt_secnum;
      cyllo_ff <= nxt_cyllo;
      cylhi_ff <= nxt_cylhi;
      head_ff <= nxt_head;
    end
  end

  // command sequencing
  always_comb begin
    nxt_phase = phase_ff;
    nxt_ptr = ptr_ff;
    nxt_err = err_ff;
    nxt_err_flag = err_flag_ff;
    nxt_fmt_lba = fmt_lba_ff;
    nxt_fmt_lba_mode = fmt_lba_mode_ff;
    nxt_fmt_done = 1'b0;
    // a new command is taken only while idle; BSY or DRQ refuse it
    if (wr_lo && phase_ff == ST_IDLE) begin
      case (idx)
        REG_STAT_CMD: begin
          nxt_ptr = 8'h00; // RULE18
          nxt_err = 8'h00;
          nxt_err_flag = 1'b0;
          if (wb_dat_i[7:0] == CMD_IDENTIFY) begin
            nxt_phase = ST_ID_PREP; // RULE4
          end else if (wb_dat_i[7:0] == CMD_FORMAT_TRACK) begin
            nxt_phase = ST_FMT_XFER; // RULE1
            // address fields captured as the command is issued
            nxt_fmt_lba = {head_ff[3:0], cylhi_ff, cyllo_ff, secnum_ff}; // RULE3
            nxt_fmt_lba_mode = head_ff[HEAD_LBA]; // RULE3
          end else begin
            // other opcodes belong elsewhere; this slice aborts them
            nxt_err[ER_ABRT] = 1'b1;
            nxt_err_flag = 1'b1;
          end
        end
        default: nxt_phase = phase_ff;
      endcase
    end
    case (phase_ff)
      ST_IDLE: nxt_phase = nxt_phase;
      ST_ID_PREP: nxt_phase = ST_ID_XFER; // first word settles in the buffer here
      ST_ID_XFER: begin
        if (take && !wb_we_i && idx == REG_DATA) begin
          nxt_ptr = ptr_ff + 8'h01; // RULE18
          if (ptr_ff == LAST_WORD) begin
            nxt_phase = ST_IDLE; // RULE4
          end
        end
      end
      ST_FMT_XFER: begin
        // words are counted and dropped; nothing reaches the media
        if (take && wb_we_i && idx == REG_DATA) begin
          nxt_ptr = ptr_ff + 8'h01; // RULE2
          if (ptr_ff == LAST_WORD) begin
            nxt_phase = ST_FMT_END; // RULE2
          end
        end
      end
      ST_FMT_END: begin
        nxt_phase = ST_IDLE;
        nxt_fmt_done = 1'b1; // RULE1
      end
      default: nxt_phase = ST_IDLE;
    endcase
  end

  // command state and format outputs
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      phase_ff <= ST_IDLE;
      ptr_ff <= 8'h00;
      err_ff <= 8'h00;
      err_flag_ff <= 1'b0;
      fmt_lba_ff <= 28'h0000000;
      fmt_lba_mode_ff <= 1'b0;
      fmt_done_ff <= 1'b0;
    end else begin
      phase_ff <= nxt_phase;
      ptr_ff <= nxt_ptr;
      err_ff <= nxt_err;
      err_flag_ff <= nxt_err_flag;
      fmt_lba_ff <= nxt_fmt_lba;
      fmt_lba_mode_ff <= nxt_fmt_lba_mode;
      fmt_done_ff <= nxt_fmt_done;
    end
  end

  // bus answer registers; read data and ack always leave together
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wb_dat_o_ff <= 32'h0000_0000;
      wb_ack_o_ff <= 1'b0;
    end else begin
      wb_dat_o_ff <= nxt_dat_o;
      wb_ack_o_ff <= nxt_ack;
    end
  end
endmodule

// ---- ata_identify_format_checker.sv ----
module ata_identify_format_checker
  import ata_ident_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o_ff,
  input wire logic wb_ack_o_ff,
  input wire logic [27:0] fmt_lba_ff,
  input wire logic fmt_lba_mode_ff,
  input wire logic fmt_done_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic req;
  logic fcmd;
  // a request counts once: the acked edge is not a new one
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o_ff;
  assign fcmd = req && wb_we_i && wb_sel_i[0] && wb_adr_i[7:2] == REG_STAT_CMD
    && wb_dat_i[7:0] == CMD_FORMAT_TRACK;
  property p_ack_resp; req |=> wb_ack_o_ff; endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("no ack after request");
  property p_ack_pulse; wb_ack_o_ff |=> !wb_ack_o_ff; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
  property p_ack_cause; wb_ack_o_ff |-> $past(req); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_word_wide; wb_ack_o_ff |-> wb_dat_o_ff[31:16] == 16'h0; endproperty
  a_word_wide: assert property (p_word_wide) else $error("upper read bits set");
  property p_unmapped;
    req && !wb_we_i && wb_adr_i[7:5] != 3'h0 |=> wb_dat_o_ff == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_lba_cause; $changed(fmt_lba_ff) |-> $past(fcmd); endproperty
  a_lba_cause: assert property (p_lba_cause) else $error("address moved alone");
  property p_mode_cause; $changed(fmt_lba_mode_ff) |-> $past(fcmd); endproperty
  a_mode_cause: assert property (p_mode_cause) else $error("mode moved alone");
  property p_done_pulse; fmt_done_ff |=> !fmt_done_ff; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done held too long");
  c_done: cover property (fmt_done_ff);
  c_word0: cover property (wb_ack_o_ff && wb_dat_o_ff[15:0] == 16'h044a);
  c_lba_mode: cover property ($rose(fmt_lba_mode_ff));
endmodule

bind ata_identify_format_responder ata_identify_format_checker u_chk (
  .clk_sys(clk_sys), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o_ff(wb_dat_o_ff), .wb_ack_o_ff(wb_ack_o_ff), .fmt_lba_ff(fmt_lba_ff),
  .fmt_lba_mode_ff(fmt_lba_mode_ff), .fmt_done_ff(fmt_done_ff));

// ---- ata_host_model.sv ----
module ata_host_model (
  input wire logic clk_sys,
  output logic wb_cyc_i,
  output logic wb_stb_i,
  output logic wb_we_i,
  output logic [7:0] wb_adr_i,
  output logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o_ff,
  input wire logic wb_ack_o_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h0;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
  end
  // one classic cycle; on release address and data are inverted so stale values never match
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    do @(posedge clk_sys); while (wb_ack_o_ff !== 1'b1);
    q = wb_dat_o_ff;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_adr_i <= ~a;
    wb_dat_i <= ~d;
  endtask
endmodule

// ---- tb_ata_identify_format_responder.sv ----
module tb_ata_identify_format_responder
  import ata_ident_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o_ff, fmt_lba_mode_ff, fmt_done_ff;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o_ff, q;
  logic [27:0] fmt_lba_ff;
  int fails, total_checks, done_n;
  always #10 clk_sys = ~clk_sys;
  ata_identify_format_responder u_ata_identify_format_responder (.clk_sys(clk_sys),
    .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o_ff(wb_dat_o_ff), .wb_ack_o_ff(wb_ack_o_ff), .fmt_lba_ff(fmt_lba_ff),
    .fmt_lba_mode_ff(fmt_lba_mode_ff), .fmt_done_ff(fmt_done_ff));
  ata_host_model u_ata_host_model (.clk_sys(clk_sys), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o_ff(wb_dat_o_ff), .wb_ack_o_ff(wb_ack_o_ff));
  // completion pulses counted here so a double pulse is seen too
  always @(posedge clk_sys) if (fmt_done_ff === 1'b1) done_n++;
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_ata_host_model.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a);
    u_ata_host_model.xfer(1'b0, a, 32'h0, q);
  endtask
  // expected word and a known flag; reserved and vendor words are checked as zero, words 5, 9, 21-22, 54-56, 60-61, 63, 85-90, 128 and 163 skipped
  function automatic logic [16:0] ew(input int i);
    logic [31:0] t;
    t = {16'h0, DEF_CYLS} * DEF_HEADS * DEF_SPT;
    if (i inside {[10:19]}) return {1'b1, 16'h2020};
    if (i inside {[23:26]}) return {1'b1, DEF_FW_REV[63-16*(i-23)-:16]};
    if (i inside {[27:46]}) return {1'b1, DEF_MODEL[319-16*(i-27)-:16]};
    if (i inside {[65:68]}) return {1'b1, 16'h0078};
    if (i inside {2, 4, 48, 50, 52, 62, [69:79], [91:127], [129:162], [164:255]})
      return 17'h10000;
    case (i)
      0: return {1'b1, 16'h044a};
      1: return {1'b1, DEF_CYLS};
      3: return {1'b1, DEF_HEADS};
      6: return {1'b1, DEF_SPT};
      7, 58: return {1'b1, t[31:16]};
      8, 57: return {1'b1, t[15:0]};
      20: return {1'b1, 16'h0002};
      47: return {1'b1, 16'h8001};
      49: return {1'b1, 16'h0b00};
      51: return {1'b1, 16'h0200};
      53: return {1'b1, 16'h0007};
      59: return {1'b1, 16'h0100};
      64: return {1'b1, 16'h0003};
      80: return {1'b1, 16'h007e};
      81: return {1'b1, 16'h0019};
      82: return {1'b1, 16'h706b};
      83: return {1'b1, 16'h400c};
      84: return {1'b1, 16'h4000};
      default: return 17'h0;
    endcase
  endfunction
  task automatic t_identify;
    logic [16:0] e;
    wr(8'h1c, 32'hec);
    do rd(8'h1c); while (q[ST_DRQ] !== 1'b1);
    for (int i = 0; i < 256; i++) begin
      rd(8'h00);
      e = ew(i);
      if (e[16]) chk($sformatf("word %0d", i), q, {16'h0, e[15:0]});
    end
    rd(8'h1c);
    chk("status after identify", q, 32'h50);
    rd(8'h00);
    chk("data past sector", q, 32'h0);
    $display("identify test done");
  endtask
  // host writes one sector after the command; a stray register write must be refused
  task automatic t_format(input logic [7:0] hd, input logic [27:0] lba);
    int n0;
    wr(8'h18, {24'h0, hd});
    wr(8'h14, 32'h12);
    wr(8'h10, 32'h34);
    wr(8'h0c, 32'h56);
    wr(8'h1c, 32'h50);
    @(negedge clk_sys);
    chk("lba", {4'h0, fmt_lba_ff}, {4'h0, lba});
    chk("lba mode", {31'h0, fmt_lba_mode_ff}, {31'h0, hd[HEAD_LBA]});
    wr(8'h14, 32'hff);
    n0 = done_n;
    for (int i = 0; i < 256; i++) begin
      chk("early done", done_n, n0);
      wr(8'h00, 32'ha5a5 ^ i);
    end
    repeat (4) @(posedge clk_sys);
    chk("done pulses", done_n, n0 + 1);
    rd(8'h1c);
    chk("status after format", q, 32'h50);
    rd(8'h14);
    chk("refused write", q, 32'h12);
    $display("format test done");
  endtask
  task automatic t_misc;
    rd(8'h20);
    chk("unmapped read", q, 32'h0);
    wr(8'h1c, 32'h00);
    rd(8'h04);
    chk("abort code", q, 32'h04);
    $display("misc test done");
  endtask
  // reset in the middle of an identify: outputs clear, the command is dropped
  task automatic t_reset;
    wr(8'h1c, 32'hec);
    do rd(8'h1c); while (q[ST_DRQ] !== 1'b1);
    rd(8'h00);
    chk("word 0 before reset", q, 32'h044a);
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (8) @(posedge clk_sys);
    chk("ack in reset", {31'h0, wb_ack_o_ff}, 32'h0);
    chk("data in reset", wb_dat_o_ff, 32'h0);
    chk("lba in reset", {4'h0, fmt_lba_ff}, 32'h0);
    chk("mode in reset", {31'h0, fmt_lba_mode_ff}, 32'h0);
    resetn <= 1'b1;
    rd(8'h1c);
    chk("status after reset", q, 32'h50);
    rd(8'h00);
    chk("data after reset", q, 32'h0);
    rd(8'h18);
    chk("head after reset", q, 32'h0);
    $display("reset test done");
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    finish_test;
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    t_identify;
    t_format(8'h4a, 28'ha123456);
    t_reset;
    t_format(8'h05, 28'h5123456);
    t_misc;
    finish_test;
  end
endmodule
